/* steer_alarm_pkg.sv */
// package: constants, register map and types for alarm supervision and logbook
package steer_alarm_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int TICK_MS = 1;
	localparam int MS_TICK_CYCLES = CLK_FREQ_KHZ * TICK_MS;
	localparam int HB_PERIOD_MS = 16;
	localparam int HB_LOSS_MS = 100;
	localparam int RX_LOSS_MS = 100;
	localparam int FROZEN_MS = 100;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WIND_RES = 8'h08;
	localparam logic [7:0] REG_MAX_CUR = 8'h0c;
	localparam logic [7:0] REG_LOG_SEL = 8'h10;
	localparam logic [7:0] REG_LOG_A = 8'h14;
	localparam logic [7:0] REG_LOG_B = 8'h18;
	localparam logic [3:0] DIAG_NO_TRACK = 4'hb;
	localparam logic [3:0] DIAG_WIPER2 = 4'hd;
	localparam logic [3:0] DIAG_NORMAL = 4'hf;
	localparam logic [15:0] WIND_RES_RST = 16'h0000;
	localparam logic [15:0] MAX_CUR_RST = 16'h0000;
	localparam logic [1:0] FB_POT = 2'h0;
	localparam logic [1:0] FB_TOGGLE = 2'h1;
	localparam logic [2:0] TOPO_0 = 3'h0;
	localparam logic [2:0] TOPO_4 = 3'h4;
	// ----------------------------------------
	// alarms
	// ----------------------------------------
	localparam logic [10:0] CAN_ALARM_ID = 11'h298;
	localparam int LOG_DEPTH = 5;
	localparam int NUM_ALARMS = 14;
	localparam logic [7:0] NUMB_WINDOW = 8'h20;
	typedef logic [7:0] code_t;
	typedef struct packed {
		code_t code;
		logic [7:0] count;
		logic [15:0] hours;
		logic [7:0] temp;
	} log_entry_s;
	typedef struct packed {
		logic [10:0] id;
		code_t code;
	} can_msg_s;
	function automatic code_t alarm_code(input logic [3:0] idx);
		case (idx)
			4'h0: alarm_code = 8'hf6;
			4'h1: alarm_code = 8'hdd;
			4'h2: alarm_code = 8'he6;
			4'h3: alarm_code = 8'hd4;
			4'h4: alarm_code = 8'h63;
			4'h5: alarm_code = 8'h06;
			4'h6: alarm_code = 8'he3;
			4'h7: alarm_code = 8'he2;
			4'h8: alarm_code = 8'hfd;
			4'h9: alarm_code = 8'he7;
			4'ha: alarm_code = 8'he8;
			4'hb: alarm_code = 8'hdc;
			4'hc: alarm_code = 8'he4;
			4'hd: alarm_code = 8'he9;
			default: alarm_code = 8'h00;
		endcase
	endfunction : alarm_code
endpackage : steer_alarm_pkg

/* loss_timer.sv */
// loss timer: flags when no restart arrived for more than a number of ms ticks
`timescale 1ns/100ps
`default_nettype none
module loss_timer #(
	parameter logic [7:0] LIMIT = 8'h64
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic tick,
	input wire logic restart,
	output logic expired
);
	import steer_alarm_pkg::*;
	logic [7:0] cnt_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 8'h00;
		end else if (restart) begin
			cnt_r <= 8'h00;
		end else if (tick && !expired) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign expired = cnt_r > LIMIT;
endmodule : loss_timer
`default_nettype wire

/* alarm_logbook.sv */
// alarm logbook: five entries, oldest dropped, repeats counted in place
`timescale 1ns/100ps
`default_nettype none
module alarm_logbook (
	input wire logic clock,
	input wire logic nrst,
	input wire logic push,
	input wire steer_alarm_pkg::code_t code,
	input wire logic [15:0] hours,
	input wire logic [7:0] temp,
	input wire logic [2:0] sel,
	output steer_alarm_pkg::log_entry_s entry,
	output logic [2:0] fill
);
	import steer_alarm_pkg::*;
	log_entry_s mem_r [LOG_DEPTH];
	logic [2:0] wr_ptr_r;
	logic [2:0] fill_r;
	logic hit;
	logic [2:0] hit_idx;

	// ----------------------------------------
	// search
	// ----------------------------------------
	always_comb begin
		hit = 1'b0;
		hit_idx = 3'h0;
		for (int i = 0; i < LOG_DEPTH; i++) begin
			if (3'(i) < fill_r && mem_r[i].code == code && !hit) begin
				hit = 1'b1;
				hit_idx = 3'(i);
			end
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < LOG_DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			wr_ptr_r <= 3'h0;
			fill_r <= 3'h0;
		end else if (push) begin
			if (hit) begin
				if (mem_r[hit_idx].count != 8'hff) begin
					mem_r[hit_idx].count <= mem_r[hit_idx].count + 8'h01;
				end
				mem_r[hit_idx].hours <= hours;
				mem_r[hit_idx].temp <= temp;
			end else begin
				mem_r[wr_ptr_r] <= '{code: code, count: 8'h01, hours: hours, temp: temp};
				wr_ptr_r <= (wr_ptr_r == 3'(LOG_DEPTH - 1)) ? 3'h0 : wr_ptr_r + 3'h1;
				if (fill_r != 3'(LOG_DEPTH)) begin
					fill_r <= fill_r + 3'h1;
				end
			end
		end
	end

	assign entry = (sel < fill_r) ? mem_r[sel] : '0;
	assign fill = fill_r;
endmodule : alarm_logbook
`default_nettype wire

/* steer_alarm_supervision_log.sv */
// top: processor cross-checks, alarm logging, CAN report and setting logic
`timescale 1ns/100ps
`default_nettype none
module steer_alarm_supervision_log #(
	parameter int MS_CYCLES = steer_alarm_pkg::MS_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic heartbeat_out,
	input wire logic heartbeat_in,
	output logic steer_cut,
	output logic traction_cut,
	input wire logic [7:0] status_bus,
	input wire logic stepper_dir_main,
	input wire logic stepper_dir_sup,
	input wire logic err_dir_main,
	input wire logic err_dir_sup,
	input wire logic limit_main,
	input wire logic limit_sup,
	input wire logic phasor_dir,
	input wire logic speed_sign,
	input wire logic cmd_pos_dir,
	input wire logic [15:0] enc_count_main,
	input wire logic [15:0] enc_count_sup,
	input wire logic sup_rx_valid,
	input wire logic main_rx_valid,
	input wire logic safety_contact_low_node,
	input wire logic contacts_close_cmd,
	input wire logic key_on,
	input wire logic safety_contact_high_node,
	input wire logic feedback_pot_stuck_alarm,
	input wire logic feedback_sensor_stuck_alarm,
	input wire logic motor_stall_alarm,
	input wire logic position_error_alarm,
	input wire logic [15:0] op_hours,
	input wire logic [7:0] inv_temp,
	output steer_alarm_pkg::can_msg_s can_msg,
	output logic can_valid,
	input wire logic can_ready,
	input wire logic [9:0] command_wiper,
	input wire logic [9:0] second_command_wiper,
	output logic [9:0] cmd_pot_reading,
	input wire logic [15:0] meas_res_mohm,
	input wire logic meas_res_valid,
	output logic dc_inject_en,
	output logic [15:0] dc_inject_level,
	output logic align_enable,
	input wire logic [7:0] wheel_angle_abs,
	input wire logic [15:0] cmd_step,
	output logic [15:0] wheel_step
);
	import steer_alarm_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0] diag_r;
	logic closed_loop_r;
	logic learn_r;
	logic [2:0] topo_r;
	logic [1:0] fb_type_r;
	logic angle_limit_r;
	logic [3:0] numb_r;
	logic [15:0] wind_res_r;
	logic [15:0] max_cur_r;
	logic [2:0] log_sel_r;
	logic wr_en;
	logic rd_hit;
	log_entry_s entry;
	logic [2:0] fill;
	logic [NUM_ALARMS-1:0] alarm;

	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			diag_r <= DIAG_NORMAL;
			closed_loop_r <= 1'b0;
			learn_r <= 1'b0;
			topo_r <= TOPO_0;
			fb_type_r <= FB_POT;
			angle_limit_r <= 1'b0;
			numb_r <= 4'h0;
			max_cur_r <= MAX_CUR_RST;
			log_sel_r <= 3'h0;
		end else if (wr_en) begin
			case (paddr)
				REG_CTRL: begin
					diag_r <= pwdata[3:0];
					closed_loop_r <= pwdata[4];
					learn_r <= pwdata[5];
					topo_r <= pwdata[8:6];
					fb_type_r <= pwdata[10:9];
					angle_limit_r <= pwdata[11];
					numb_r <= pwdata[15:12];
				end
				REG_MAX_CUR: max_cur_r <= pwdata[15:0];
				REG_LOG_SEL: log_sel_r <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// winding resistance: measurement or software, measurement only while learning
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wind_res_r <= WIND_RES_RST;
		end else if (wr_en && paddr == REG_WIND_RES) begin
			wind_res_r <= pwdata[15:0];
		end else if (learn_r && meas_res_valid) begin
			wind_res_r <= meas_res_mohm;
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			REG_CTRL: prdata = {16'h0000, numb_r, angle_limit_r, fb_type_r, topo_r, learn_r,
				closed_loop_r, diag_r};
			REG_STATUS: prdata = {13'h0000, fill, align_enable, steer_cut, alarm};
			REG_WIND_RES: prdata = {16'h0000, wind_res_r};
			REG_MAX_CUR: prdata = {16'h0000, max_cur_r};
			REG_LOG_SEL: prdata = {29'h0000_0000, log_sel_r};
			REG_LOG_A: prdata = {16'h0000, entry.count, entry.code};
			REG_LOG_B: prdata = {8'h00, entry.temp, entry.hours};
			default: rd_hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !rd_hit;

	// ----------------------------------------
	// millisecond tick and heartbeat out
	// ----------------------------------------
	logic [31:0] div_r;
	logic tick;
	logic [3:0] hb_cnt_r;

	assign tick = div_r == 32'(MS_CYCLES - 1);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			div_r <= 32'h0;
		end else begin
			div_r <= tick ? 32'h0 : div_r + 32'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hb_cnt_r <= 4'h0;
			heartbeat_out <= 1'b0;
		end else if (tick) begin
			hb_cnt_r <= (hb_cnt_r == 4'(HB_PERIOD_MS - 1)) ? 4'h0 : hb_cnt_r + 4'h1;
			heartbeat_out <= hb_cnt_r == 4'h0;
		end
	end

	// ----------------------------------------
	// watchdogs
	// ----------------------------------------
	logic hb_in_d_r;
	logic hb_lost;
	logic main_lost;
	logic sup_lost;
	logic frozen;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hb_in_d_r <= 1'b0;
		end else begin
			hb_in_d_r <= heartbeat_in;
		end
	end

	loss_timer #(.LIMIT(8'(HB_LOSS_MS))) u_hb_timer (
		.clock(clock),
		.nrst(nrst),
		.tick(tick),
		.restart(heartbeat_in != hb_in_d_r),
		.expired(hb_lost)
	);

	loss_timer #(.LIMIT(8'(RX_LOSS_MS))) u_sup_rx_timer (
		.clock(clock),
		.nrst(nrst),
		.tick(tick),
		.restart(sup_rx_valid),
		.expired(sup_lost)
	);

	loss_timer #(.LIMIT(8'(RX_LOSS_MS))) u_main_rx_timer (
		.clock(clock),
		.nrst(nrst),
		.tick(tick),
		.restart(main_rx_valid),
		.expired(main_lost)
	);

	loss_timer #(.LIMIT(8'(FROZEN_MS))) u_frozen_timer (
		.clock(clock),
		.nrst(nrst),
		.tick(tick),
		.restart(status_bus != 8'hff),
		.expired(frozen)
	);

	assign steer_cut = hb_lost;
	assign traction_cut = hb_lost;

	// ----------------------------------------
	// key-on contact check
	// ----------------------------------------
	logic key_d_r;
	logic early_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			key_d_r <= 1'b0;
			early_r <= 1'b0;
		end else begin
			key_d_r <= key_on;
			if (key_on && !key_d_r) begin
				early_r <= safety_contact_high_node && !contacts_close_cmd;
			end
		end
	end

	// ----------------------------------------
	// alarm conditions
	// ----------------------------------------
	logic track_on;
	assign track_on = diag_r != DIAG_NO_TRACK;

	always_comb begin
		alarm[0] = (closed_loop_r ? err_dir_main != err_dir_sup
			: stepper_dir_main != stepper_dir_sup)
			|| (!limit_main && limit_sup);
		alarm[1] = closed_loop_r ? phasor_dir != cmd_pos_dir : phasor_dir != speed_sign;
		alarm[2] = frozen;
		alarm[3] = enc_count_main != enc_count_sup;
		alarm[4] = safety_contact_low_node && !contacts_close_cmd;
		alarm[5] = sup_lost;
		alarm[6] = main_lost;
		alarm[7] = hb_lost;
		alarm[8] = early_r;
		alarm[9] = feedback_pot_stuck_alarm && track_on;
		alarm[10] = feedback_sensor_stuck_alarm && track_on;
		alarm[11] = motor_stall_alarm && track_on;
		alarm[12] = position_error_alarm && track_on;
		alarm[13] = learn_r;
	end

	// ----------------------------------------
	// alarm queue to logbook and CAN
	// ----------------------------------------
	logic [NUM_ALARMS-1:0] alarm_d_r;
	logic [NUM_ALARMS-1:0] pend_r;
	logic [NUM_ALARMS-1:0] take;
	logic [3:0] pick;
	logic issue;

	always_comb begin
		pick = 4'h0;
		take = '0;
		for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				pick = 4'(i);
			end
		end
		issue = (pend_r != '0) && (!can_valid || can_ready);
		if (issue) begin
			take[pick] = 1'b1;
		end
	end

	// new rise wins over the clear of the same bit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			alarm_d_r <= '0;
			pend_r <= '0;
		end else begin
			alarm_d_r <= alarm;
			pend_r <= (pend_r & ~take) | (alarm & ~alarm_d_r);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			can_valid <= 1'b0;
			can_msg <= '0;
		end else if (issue) begin
			can_valid <= 1'b1;
			can_msg <= '{id: CAN_ALARM_ID, code: alarm_code(pick)};
		end else if (can_ready) begin
			can_valid <= 1'b0;
		end
	end

	alarm_logbook u_logbook (
		.clock(clock),
		.nrst(nrst),
		.push(issue),
		.code(alarm_code(pick)),
		.hours(op_hours),
		.temp(inv_temp),
		.sel(log_sel_r),
		.entry(entry),
		.fill(fill)
	);

	// ----------------------------------------
	// settings driven outputs
	// ----------------------------------------
	logic [19:0] numb_prod;
	logic near_centre;
	assign numb_prod = cmd_step * {16'h0000, numb_r};
	assign near_centre = wheel_angle_abs < NUMB_WINDOW;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmd_pot_reading <= 10'h000;
			dc_inject_en <= 1'b0;
			dc_inject_level <= 16'h0000;
			align_enable <= 1'b0;
			wheel_step <= 16'h0000;
		end else begin
			cmd_pot_reading <= (diag_r == DIAG_WIPER2) ? second_command_wiper : command_wiper;
			dc_inject_en <= learn_r;
			dc_inject_level <= learn_r ? {1'b0, max_cur_r[15:1]} : 16'h0000;
			if (fb_type_r == FB_TOGGLE) begin
				align_enable <= topo_r == TOPO_0;
			end else begin
				align_enable <= (topo_r == TOPO_0 || topo_r == TOPO_4)
					&& (fb_type_r != FB_POT || angle_limit_r);
			end
			if (numb_r == 4'h0 || !near_centre) begin
				wheel_step <= cmd_step;
			end else begin
				wheel_step <= cmd_step - numb_prod[19:4];
			end
		end
	end
endmodule : steer_alarm_supervision_log
`default_nettype wire

/* steer_alarm_supervision_log_sva.sv */
// checker: port-level properties of the alarm supervision block
`timescale 1ns/100ps
`default_nettype none
module steer_alarm_supervision_log_chk #(
	parameter int MS_CYCLES = steer_alarm_pkg::MS_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic heartbeat_out,
	input wire logic heartbeat_in,
	input wire logic steer_cut,
	input wire logic traction_cut,
	input wire steer_alarm_pkg::can_msg_s can_msg,
	input wire logic can_valid,
	input wire logic can_ready,
	input wire logic dc_inject_en,
	input wire logic [15:0] dc_inject_level,
	input wire logic [7:0] wheel_angle_abs,
	input wire logic [15:0] cmd_step,
	input wire logic [15:0] wheel_step
);
	import steer_alarm_pkg::*;
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	logic [15:0] hb_cnt_r;
	logic hb_seen_r;
	logic [15:0] in_cnt_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hb_cnt_r <= 16'h0000;
			hb_seen_r <= 1'b0;
		end else if ($rose(heartbeat_out)) begin
			hb_cnt_r <= 16'h0001;
			hb_seen_r <= 1'b1;
		end else if (hb_cnt_r != 16'hffff) begin
			hb_cnt_r <= hb_cnt_r + 16'h0001;
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			in_cnt_r <= 16'h0000;
		end else if ($changed(heartbeat_in)) begin
			in_cnt_r <= 16'h0000;
		end else if (in_cnt_r != 16'hffff) begin
			in_cnt_r <= in_cnt_r + 16'h0001;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	hb_period_a: assert property ($rose(heartbeat_out) && hb_seen_r |-> hb_cnt_r == 16 * MS_CYCLES)
		else $error("heartbeat period wrong");
	hb_width_a: assert property ($fell(heartbeat_out) |-> hb_cnt_r == MS_CYCLES)
		else $error("heartbeat width wrong");
	cut_early_a: assert property (steer_cut |-> in_cnt_r >= 100 * MS_CYCLES)
		else $error("cut without heartbeat loss");
	cut_late_a: assert property (in_cnt_r >= 104 * MS_CYCLES |-> steer_cut)
		else $error("heartbeat loss not cut");
	cut_pair_a: assert property (steer_cut == traction_cut)
		else $error("steer and traction cut differ");
	can_id_a: assert property (can_valid |-> can_msg.id == 11'h298)
		else $error("wrong message identifier");
	can_hold_a: assert property (can_valid && !can_ready |=> can_valid && $stable(can_msg))
		else $error("message dropped before taken");
	inject_off_a: assert property (!dc_inject_en |-> dc_inject_level == 16'h0000)
		else $error("current level without injection");
	step_linear_a: assert property (wheel_angle_abs >= 8'h20 |=> wheel_step == $past(cmd_step))
		else $error("step scaled away from centre");
	apb_bad_a: assert property (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'b00)
		|-> pslverr && pready && prdata == 32'h0) else $error("unmapped access not refused");
	cover property (can_valid && !can_ready);
	cover property ($rose(steer_cut));
	cover property (dc_inject_en);
endmodule : steer_alarm_supervision_log_chk
bind steer_alarm_supervision_log steer_alarm_supervision_log_chk #(.MS_CYCLES(MS_CYCLES)) chk_i (
	.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .heartbeat_out(heartbeat_out), .heartbeat_in(heartbeat_in),
	.steer_cut(steer_cut), .traction_cut(traction_cut), .can_msg(can_msg), .can_valid(can_valid),
	.can_ready(can_ready), .dc_inject_en(dc_inject_en), .dc_inject_level(dc_inject_level),
	.wheel_angle_abs(wheel_angle_abs), .cmd_step(cmd_step), .wheel_step(wheel_step));
`default_nettype wire

/* sup_model.sv */
// supervisor and bus node model: heartbeat echo, link traffic, message acceptance
`timescale 1ns/100ps
`default_nettype none
module sup_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hb_out,
	input wire logic quiet,
	input wire logic stall,
	output logic hb_in,
	output logic sup_rx,
	output logic main_rx,
	output logic can_ready
);
	logic [5:0] cnt_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 6'h00;
			hb_in <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 6'h01;
			hb_in <= quiet ? hb_in : hb_out;
		end
	end
	// link messages stop when quiet; acceptance slowed under stall
	assign sup_rx = !quiet && cnt_r == 6'h3f;
	assign main_rx = !quiet && cnt_r == 6'h1f;
	assign can_ready = !stall || cnt_r[1:0] == 2'b00;
endmodule : sup_model
`default_nettype wire

/* steer_alarm_supervision_log_bench.sv */
// bench: register, alarm, logbook and setting scenarios
`timescale 1ns/100ps
`default_nettype none
module steer_alarm_supervision_log_bench;
	import steer_alarm_pkg::*;
	logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, quiet = 0, stall = 0;
	logic [7:0] paddr = 0, status_bus = 0, inv_temp = 0, wheel_angle_abs = 8'h10;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, heartbeat_out, heartbeat_in, steer_cut, traction_cut, can_valid, can_ready;
	logic stepper_dir_main = 0, stepper_dir_sup = 0, err_dir_main = 0, err_dir_sup = 0;
	logic limit_main = 0, limit_sup = 0, phasor_dir = 0, speed_sign = 0, cmd_pos_dir = 0;
	logic sup_rx_valid, main_rx_valid, safety_contact_low_node = 0, contacts_close_cmd = 0;
	logic key_on = 0, safety_contact_high_node = 0, feedback_pot_stuck_alarm = 0;
	logic feedback_sensor_stuck_alarm = 0, motor_stall_alarm = 0, position_error_alarm = 0;
	logic [15:0] enc_count_main = 0, enc_count_sup = 0, op_hours = 0, meas_res_mohm = 0;
	logic [15:0] dc_inject_level, cmd_step = 16'h0100, wheel_step;
	logic [9:0] command_wiper = 10'h155, second_command_wiper = 10'h2aa, cmd_pot_reading;
	logic meas_res_valid = 0, dc_inject_en, align_enable;
	can_msg_s can_msg;
	code_t q[$];
	int n_errors = 0, cmp_count = 0;
	always #4 clock = ~clock;
	steer_alarm_supervision_log #(.MS_CYCLES(10)) dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .heartbeat_out, .heartbeat_in, .steer_cut, .traction_cut,
		.status_bus, .stepper_dir_main, .stepper_dir_sup, .err_dir_main, .err_dir_sup, .limit_main,
		.limit_sup, .phasor_dir, .speed_sign, .cmd_pos_dir, .enc_count_main, .enc_count_sup,
		.sup_rx_valid, .main_rx_valid, .safety_contact_low_node, .contacts_close_cmd, .key_on,
		.safety_contact_high_node, .feedback_pot_stuck_alarm, .feedback_sensor_stuck_alarm,
		.motor_stall_alarm, .position_error_alarm, .op_hours, .inv_temp, .can_msg, .can_valid,
		.can_ready, .command_wiper, .second_command_wiper, .cmd_pot_reading, .meas_res_mohm,
		.meas_res_valid, .dc_inject_en, .dc_inject_level, .align_enable, .wheel_angle_abs, .cmd_step,
		.wheel_step);
	sup_model partner (.clock, .nrst, .hb_out(heartbeat_out), .quiet, .stall, .hb_in(heartbeat_in),
		.sup_rx(sup_rx_valid), .main_rx(main_rx_valid), .can_ready);
	always @(posedge clock) begin
		if (can_valid === 1'b1 && can_ready === 1'b1) q.push_back(can_msg.code);
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task wrap_up;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			n_errors++;
			$display("BAD t=%0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			n_errors++;
			wrap_up();
		end
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(0, a, 32'h0, r, e);
		chk(r, x);
	endtask : rdc
	task exp_can(input code_t c);
		int i;
		i = 0;
		while (q.size() == 0 && i < 60) begin
			@(posedge clock);
			i++;
		end
		if (q.size() == 0) chk(32'h0, {24'h0, c});
		else chk({24'h0, q.pop_front()}, {24'h0, c});
	endtask : exp_can
	task set_al(input int k, input logic v);
		case (k)
			0: enc_count_sup <= {15'h0, v};
			1: limit_sup <= v;
			2: speed_sign <= v;
			3: safety_contact_low_node <= v;
			4: begin
				safety_contact_high_node <= v;
				key_on <= v;
			end
			5: stepper_dir_sup <= v;
			default: err_dir_sup <= v;
		endcase
	endtask : set_al
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		automatic code_t cd[7] = '{8'hd4, 8'hf6, 8'hdd, 8'h63, 8'hfd, 8'hf6, 8'hf6};
		automatic logic [31:0] at[6] = '{32'h80f, 32'h90f, 32'h00f, 32'h88f, 32'h20f, 32'h30f};
		automatic logic ae[6] = '{1, 1, 0, 0, 1, 0};
		logic [31:0] r;
		logic e;
		logic [3:0] m;
		int i;
		cyc(4);
		nrst <= 1;
		@(posedge clock);
		rdc(REG_CTRL, 32'h0000000f);
		apb(0, 8'h40, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		stall <= 1;
		for (i = 0; i < 7; i++) begin
			if (i == 6) wr(REG_CTRL, 32'h1f);
			op_hours <= (i < 5) ? 16'h0100 + i[15:0] : 16'h0200;
			inv_temp <= (i < 5) ? 8'h30 + i[7:0] : 8'h40;
			set_al(i, 1);
			exp_can(cd[i]);
			set_al(i, 0);
			cyc(3);
		end
		wr(REG_CTRL, 32'hf);
		for (i = 0; i < 5; i++) begin
			wr(REG_LOG_SEL, i);
			rdc(REG_LOG_A, {16'h0, (i == 1) ? 8'h03 : 8'h01, cd[i]});
			rdc(REG_LOG_B, (i == 1) ? 32'h00400200 : {8'h0, 8'h30 + i[7:0], 16'h0100 + i[15:0]});
		end
		wr(REG_MAX_CUR, 32'h100);
		wr(REG_CTRL, 32'h2f);
		exp_can(8'he9);
		chk({dc_inject_en, dc_inject_level}, 17'h10080);
		meas_res_mohm <= 16'h1234;
		meas_res_valid <= 1;
		cyc(1);
		meas_res_valid <= 0;
		rdc(REG_WIND_RES, 32'h1234);
		wr(REG_CTRL, 32'hf);
		cyc(2);
		chk({dc_inject_en, dc_inject_level}, 17'h0);
		rdc(REG_WIND_RES, 32'h1234);
		apb(0, REG_STATUS, 32'h0, r, e);
		chk({r[18:16], r[13]}, 4'ha);
		wr(REG_LOG_SEL, 0);
		rdc(REG_LOG_A, 32'h01e9);
		wr(REG_WIND_RES, 32'h0555);
		rdc(REG_WIND_RES, 32'h0555);
		wr(REG_CTRL, 32'hb);
		motor_stall_alarm <= 1;
		cyc(30);
		chk(q.size(), 0);
		motor_stall_alarm <= 0;
		wr(REG_CTRL, 32'hf);
		position_error_alarm <= 1;
		exp_can(8'he4);
		position_error_alarm <= 0;
		wr(REG_CTRL, 32'hd);
		cyc(2);
		chk(cmd_pot_reading, 10'h2aa);
		wr(REG_CTRL, 32'hf);
		cyc(2);
		chk(cmd_pot_reading, 10'h155);
		chk(wheel_step, 16'h0100);
		wr(REG_CTRL, 32'h800f);
		cyc(2);
		chk(wheel_step, 16'h0080);
		wheel_angle_abs <= 8'h40;
		cyc(2);
		chk(wheel_step, 16'h0100);
		wheel_angle_abs <= 8'h10;
		for (i = 0; i < 6; i++) begin
			wr(REG_CTRL, at[i]);
			cyc(2);
			chk(align_enable, ae[i]);
		end
		status_bus <= 8'hff;
		quiet <= 1;
		i = 0;
		while (steer_cut !== 1'b1 && i < 1500) begin
			cyc(1);
			i++;
		end
		chk({steer_cut, traction_cut}, 2'b11);
		cyc(250);
		m = 0;
		foreach (q[j]) m = m | {q[j] == 8'he2, q[j] == 8'he6, q[j] == 8'h06, q[j] == 8'he3};
		chk(m[3], 1);
		chk(m[2], 1);
		chk(m[1], 1);
		chk(m[0], 1);
		wrap_up();
	end
	initial begin
		#800000;
		n_errors++;
		wrap_up();
	end
endmodule : steer_alarm_supervision_log_bench
`default_nettype wire
